// File: hdl/flag_bus_pkg.sv
package flag_bus_pkg;

  localparam int          QUEUE_COUNT_MAX = 8;
  localparam int          DEV_NUM_W       = 3;
  localparam int          QADDR_W         = 6;
  localparam int          QADDR_DEV_LSB   = 3;
  localparam int          APB_ADDR_W      = 8;
  localparam int          APB_DATA_W      = 32;
  localparam int          QCOUNT_W        = 4;

  // Register byte addresses on the APB port.
  localparam logic [7:0]  ADDR_CTRL       = 8'h00;
  localparam logic [7:0]  ADDR_STATUS     = 8'h04;

  // Control register: number of configured queues in the low bits.
  localparam logic [3:0]  QCOUNT_RESET    = 4'h8;
  localparam int          CTRL_QCOUNT_LSB = 0;

  // Status register field positions.
  localparam int          ST_STYLE_BIT    = 0;
  localparam int          ST_PACKET_BIT   = 1;
  localparam int          ST_LEADER_BIT   = 2;
  localparam int          ST_EMPTY_BIT    = 3;
  localparam int          ST_FULL_BIT     = 4;
  localparam int          ST_RUN_BIT      = 5;

  // Bus selection styles latched at master reset.
  typedef enum logic {
    STYLE_ADDRESSED,
    STYLE_POLLED
  } select_style_t;

  // Next-cycle state of one shared flag bus.
  typedef struct packed {
    logic       hold;
    logic       drive;
    logic       token;
    logic       pulse;
  } bus_side_t;

  // Shared bus pins of one side.
  typedef struct packed {
    logic       oe;
    logic [7:0] value;
  } bus_pins_t;

endpackage : flag_bus_pkg

// File: hdl/queue_flag_bus_expansion.sv
// The register addresses and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps

// Operation
// RQ1: Every queue has its own empty-side status shown on the shared bus.
// RQ2: Empty-side bus is eight bits, one per queue, all shown at once.
// RQ3: Packet mode at master reset selects packet-ready, else almost-empty status.
// RQ4: Queues one to eight drive bus bits zero to seven.
// RQ5: Bits of unconfigured queues are don't care for the observer.
// RQ6: Only one device drives a shared bus; others stay high impedance.
// RQ7: Style input at master reset picks addressed or token-polled selection.
// RQ8: Addressed: strobe with top read-address bits equal to device number selects.
// RQ9: Top three read-address bits compare with device number pins.
// RQ10: Bus shows new device status one read cycle after selection.
// RQ11: A queue bit may lag one extra cycle on a same-cycle switch.
// RQ12: Controller never selects read queue and bus device together.
// RQ13: Polled leader drives empty-side bus on first edge after master reset.
// RQ14: Polled leader pulses empty sync one cycle while holding bus.
// RQ15: Empty token out high while holding; next device holds following cycle.
// RQ16: Board ties empty token outputs into a closed ring.
// RQ17: Exactly one device in a chain is the leader.
// RQ18: Polled leader drives almost-full bus on first edge after master reset.
// RQ19: Polled leader pulses full sync one cycle while holding bus.
// RQ20: Full token out high while holding; next device holds following cycle.
// RQ21: Board ties full token outputs into a closed ring.
// RQ22: Addressed full bus: strobe with top write-address bits selects, shows next cycle.
// RQ23: A device not holding a bus keeps its outputs released.
// RQ24: Without a token in last cycle, token out stays low and bus released.
module queue_flag_bus_expansion #(
  parameter int QUEUES = flag_bus_pkg::QUEUE_COUNT_MAX
) (
  // Clock and reset
  input  wire logic                                  CLK_I,
  input  wire logic                                  RST_N_I,
  // APB register port
  input  wire logic                                  PSEL_I,
  input  wire logic                                  PENABLE_I,
  input  wire logic                                  PWRITE_I,
  input  wire logic [flag_bus_pkg::APB_ADDR_W-1:0]   PADDR_I,
  input  wire logic [flag_bus_pkg::APB_DATA_W-1:0]   PWDATA_I,
  output logic      [flag_bus_pkg::APB_DATA_W-1:0]   PRDATA_O,
  output logic                                       PREADY_O,
  output logic                                       PSLVERR_O,
  // Configuration straps, sampled while master reset is low
  input  wire logic                                  MASTER_RESET_N_I,
  input  wire logic                                  FLAG_BUS_SELECT_STYLE_I,
  input  wire logic                                  PACKET_MODE_SELECT_I,
  input  wire logic                                  CHAIN_LEADER_SELECT_I,
  input  wire logic [flag_bus_pkg::DEV_NUM_W-1:0]    DEVICE_NUMBER_PINS_I,
  // Per-queue status from the queue datapath, active low
  input  wire logic [QUEUES-1:0]                     ALMOST_EMPTY_FLAG_I,
  input  wire logic [QUEUES-1:0]                     PACKET_READY_FLAG_I,
  input  wire logic [QUEUES-1:0]                     ALMOST_FULL_FLAG_I,
  // Empty-side bus selection and ring
  input  wire logic [flag_bus_pkg::QADDR_W-1:0]      READ_QUEUE_ADDRESS_I,
  input  wire logic                                  EMPTY_BUS_STROBE_I,
  input  wire logic                                  EMPTY_TOKEN_IN_I,
  output logic                                       EMPTY_TOKEN_OUT_O,
  output logic                                       EMPTY_BUS_LEADER_PULSE_O,
  output logic [QUEUES-1:0]                          EMPTY_SIDE_STATUS_BUS_O,
  output logic                                       EMPTY_SIDE_STATUS_BUS_OE_O,
  // Full-side bus selection and ring
  input  wire logic [flag_bus_pkg::QADDR_W-1:0]      WRITE_QUEUE_ADDRESS_I,
  input  wire logic                                  FULL_BUS_STROBE_I,
  input  wire logic                                  FULL_TOKEN_IN_I,
  output logic                                       FULL_TOKEN_OUT_O,
  output logic                                       FULL_BUS_LEADER_PULSE_O,
  output logic [QUEUES-1:0]                          ALMOST_FULL_STATUS_BUS_O,
  output logic                                       ALMOST_FULL_STATUS_BUS_OE_O
);
  import flag_bus_pkg::*;

  // Flags are active low, so unconfigured queues read inactive high.
  function automatic logic [QUEUES-1:0] bus_value(input logic [QUEUES-1:0] flags,
                                                   input logic [QCOUNT_W-1:0] count);
    logic [QUEUES-1:0] v;
    v = flags;
    for (int q = 0; q < QUEUES; q++) begin
      if (q >= int'(count)) begin
        v[q] = 1'b1; // see RQ5
      end
    end
    return v; // see RQ4
  endfunction : bus_value

  // One cycle of bus ownership for either side.
  function automatic bus_side_t side_next(input logic mrs_n, input logic first_edge,
                                          input select_style_t style, input logic leader,
                                          input logic token_in, input logic strobe,
                                          input logic [DEV_NUM_W-1:0] addr_hi,
                                          input logic [DEV_NUM_W-1:0] dev_num,
                                          input logic hold);
    bus_side_t s;
    s = '0;
    if (!mrs_n) begin
      s = '0;
    end else if (style == STYLE_POLLED) begin
      s.hold  = first_edge ? leader : token_in; // see RQ13, RQ18, RQ24
      s.drive = s.hold;                          // see RQ23
      s.token = s.hold;                          // see RQ15, RQ20
      s.pulse = s.hold & leader;                 // see RQ14, RQ19
    end else begin
      s.hold  = strobe ? (addr_hi == dev_num) : hold; // see RQ8, RQ9, RQ22, RQ12
      s.drive = hold;                                 // see RQ10, RQ6
    end
    return s;
  endfunction : side_next

  logic                      rst_meta;
  logic                      rst_n;
  logic                      mrs_q;
  select_style_t             style;
  logic                      packet_mode;
  logic                      leader;
  logic [DEV_NUM_W-1:0]      dev_num;
  logic [QCOUNT_W-1:0]       qcount;
  logic                      empty_hold;
  logic                      full_hold;

  wire                       first_edge = MASTER_RESET_N_I & ~mrs_q;
  wire  [QUEUES-1:0]         empty_src  = packet_mode ? PACKET_READY_FLAG_I : ALMOST_EMPTY_FLAG_I; // see RQ3, RQ1
  wire  [QUEUES-1:0]         next_empty_value = bus_value(empty_src, qcount);                     // see RQ2
  wire  [QUEUES-1:0]         next_full_value  = bus_value(ALMOST_FULL_FLAG_I, qcount);

  wire  bus_side_t           next_empty = side_next(MASTER_RESET_N_I, first_edge, style, leader,
                                                    EMPTY_TOKEN_IN_I, EMPTY_BUS_STROBE_I,
                                                    READ_QUEUE_ADDRESS_I[QADDR_W-1:QADDR_DEV_LSB],
                                                    dev_num, empty_hold); // see RQ7
  wire  bus_side_t           next_full  = side_next(MASTER_RESET_N_I, first_edge, style, leader,
                                                    FULL_TOKEN_IN_I, FULL_BUS_STROBE_I,
                                                    WRITE_QUEUE_ADDRESS_I[QADDR_W-1:QADDR_DEV_LSB],
                                                    dev_num, full_hold);

  // APB decode; answers arrive one cycle into the access phase.
  wire                       apb_access = PSEL_I & PENABLE_I & ~PREADY_O;
  wire                       hit_ctrl   = (PADDR_I == ADDR_CTRL);
  wire                       hit_status = (PADDR_I == ADDR_STATUS);
  wire                       apb_ok     = hit_ctrl | (hit_status & ~PWRITE_I);
  wire                       ctrl_wr    = apb_access & PWRITE_I & hit_ctrl;
  wire  [APB_DATA_W-1:0]     status_word = APB_DATA_W'({mrs_q,
                                                        full_hold, empty_hold, leader,
                                                        packet_mode, style == STYLE_POLLED});
  wire  [APB_DATA_W-1:0]     ctrl_word   = APB_DATA_W'(qcount) << CTRL_QCOUNT_LSB;
  wire  [APB_DATA_W-1:0]     next_prdata = (~apb_ok | PWRITE_I) ? '0 :
                                           hit_ctrl ? ctrl_word : status_word;

  // Reset release through two stages; assertion stays asynchronous.
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // Straps are caught by the clock while master reset is held, never by the reset itself.
  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      mrs_q       <= 1'b0;
      style       <= STYLE_ADDRESSED;
      packet_mode <= 1'b0;
      leader      <= 1'b0;
      dev_num     <= '0;
    end else begin
      mrs_q <= MASTER_RESET_N_I;
      if (!MASTER_RESET_N_I) begin
        style       <= select_style_t'(FLAG_BUS_SELECT_STYLE_I); // see RQ7
        packet_mode <= PACKET_MODE_SELECT_I;                     // see RQ3
        leader      <= CHAIN_LEADER_SELECT_I;                    // see RQ17
        dev_num     <= DEVICE_NUMBER_PINS_I;
      end
    end
  end

  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      empty_hold                  <= 1'b0;
      EMPTY_SIDE_STATUS_BUS_OE_O  <= 1'b0;
      EMPTY_SIDE_STATUS_BUS_O     <= '1;
      EMPTY_TOKEN_OUT_O           <= 1'b0;
      EMPTY_BUS_LEADER_PULSE_O    <= 1'b0;
    end else begin
      empty_hold                  <= next_empty.hold;
      EMPTY_SIDE_STATUS_BUS_OE_O  <= next_empty.drive; // see RQ6, RQ23
      EMPTY_SIDE_STATUS_BUS_O     <= next_empty_value; // see RQ11
      EMPTY_TOKEN_OUT_O           <= next_empty.token; // see RQ15
      EMPTY_BUS_LEADER_PULSE_O    <= next_empty.pulse; // see RQ14
    end
  end

  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      full_hold                   <= 1'b0;
      ALMOST_FULL_STATUS_BUS_OE_O <= 1'b0;
      ALMOST_FULL_STATUS_BUS_O    <= '1;
      FULL_TOKEN_OUT_O            <= 1'b0;
      FULL_BUS_LEADER_PULSE_O     <= 1'b0;
    end else begin
      full_hold                   <= next_full.hold;
      ALMOST_FULL_STATUS_BUS_OE_O <= next_full.drive; // see RQ22, RQ23
      ALMOST_FULL_STATUS_BUS_O    <= next_full_value;
      FULL_TOKEN_OUT_O            <= next_full.token; // see RQ20
      FULL_BUS_LEADER_PULSE_O     <= next_full.pulse; // see RQ19
    end
  end

  // Queue count only masks bus bits; it does not touch ownership.
  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      qcount    <= QCOUNT_RESET;
      PREADY_O  <= 1'b0;
      PSLVERR_O <= 1'b0;
      PRDATA_O  <= '0;
    end else begin
      PREADY_O  <= apb_access;
      PSLVERR_O <= apb_access & ~apb_ok;
      PRDATA_O  <= apb_access ? next_prdata : '0;
      if (ctrl_wr) begin
        qcount <= PWDATA_I[CTRL_QCOUNT_LSB +: QCOUNT_W];
      end
    end
  end

endmodule : queue_flag_bus_expansion

// File: sim/flag_ring_partner.sv
`timescale 1ns/1ps

// Neighbouring device: it holds the bus in the cycle after our token.
// As leader it also starts the ring on the first edge after master reset.
module flag_ring_partner (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic leader_i,
  input  wire logic token_in_i,
  output logic      token_out_o
);
  logic started;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      started     <= 1'b0;
      token_out_o <= 1'b0;
    end else begin
      started     <= 1'b1;
      token_out_o <= started ? token_in_i : leader_i;
    end
  end
endmodule : flag_ring_partner

// File: sim/queue_flag_bus_expansion_asserts.sv
`timescale 1ns/1ps

module queue_flag_bus_expansion_asserts #(
  parameter int QUEUES = 8
) (
  input wire logic CLK_I, RST_N_I, MASTER_RESET_N_I, FLAG_BUS_SELECT_STYLE_I, PACKET_MODE_SELECT_I,
  input wire logic [2:0] DEVICE_NUMBER_PINS_I,
  input wire logic [QUEUES-1:0] ALMOST_EMPTY_FLAG_I, PACKET_READY_FLAG_I, ALMOST_FULL_FLAG_I,
  input wire logic [5:0] READ_QUEUE_ADDRESS_I, WRITE_QUEUE_ADDRESS_I,
  input wire logic EMPTY_BUS_STROBE_I, EMPTY_TOKEN_IN_I, FULL_BUS_STROBE_I, FULL_TOKEN_IN_I,
  input wire logic EMPTY_TOKEN_OUT_O, EMPTY_BUS_LEADER_PULSE_O, EMPTY_SIDE_STATUS_BUS_OE_O,
  input wire logic FULL_TOKEN_OUT_O, FULL_BUS_LEADER_PULSE_O, ALMOST_FULL_STATUS_BUS_OE_O,
  input wire logic [QUEUES-1:0] EMPTY_SIDE_STATUS_BUS_O, ALMOST_FULL_STATUS_BUS_O
);
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);
  // The device number strap is only compared while addressed mode is in use.
  wire logic adr = !FLAG_BUS_SELECT_STYLE_I;
  wire logic e_hit = EMPTY_BUS_STROBE_I && (READ_QUEUE_ADDRESS_I[5:3] == DEVICE_NUMBER_PINS_I);
  wire logic f_hit = FULL_BUS_STROBE_I && (WRITE_QUEUE_ADDRESS_I[5:3] == DEVICE_NUMBER_PINS_I);
  wire logic e_src = PACKET_MODE_SELECT_I ? PACKET_READY_FLAG_I[0] : ALMOST_EMPTY_FLAG_I[0];
  wire logic f_src = ALMOST_FULL_FLAG_I[0];

  AST_E_TOKEN_OE: assert property (EMPTY_TOKEN_OUT_O |-> EMPTY_SIDE_STATUS_BUS_OE_O)
    else $error("empty token high while bus released");
  AST_E_RING: assert property (EMPTY_TOKEN_OUT_O && !EMPTY_BUS_LEADER_PULSE_O |-> $past(EMPTY_TOKEN_IN_I))
    else $error("empty token taken without token in");
  AST_F_RING: assert property (FULL_TOKEN_OUT_O && !FULL_BUS_LEADER_PULSE_O |-> $past(FULL_TOKEN_IN_I))
    else $error("full token taken without token in");
  AST_E_PULSE: assert property (EMPTY_BUS_LEADER_PULSE_O && !EMPTY_TOKEN_IN_I |=> !EMPTY_BUS_LEADER_PULSE_O)
    else $error("empty leader pulse longer than one cycle");
  AST_F_PULSE: assert property (FULL_BUS_LEADER_PULSE_O |-> FULL_TOKEN_OUT_O ##1 !FULL_BUS_LEADER_PULSE_O)
    else $error("full leader pulse wrong");
  AST_E_SEL: assert property (e_hit && adr && MASTER_RESET_N_I ##1 MASTER_RESET_N_I |=> EMPTY_SIDE_STATUS_BUS_OE_O)
    else $error("empty bus not taken after selection");
  AST_E_DESEL: assert property (EMPTY_BUS_STROBE_I && !e_hit && adr |-> ##2 !EMPTY_SIDE_STATUS_BUS_OE_O)
    else $error("empty bus still driven after deselection");
  AST_F_DESEL: assert property (FULL_BUS_STROBE_I && !f_hit && adr |-> ##2 !ALMOST_FULL_STATUS_BUS_OE_O)
    else $error("full bus still driven after deselection");
  AST_E_VAL: assert property (EMPTY_SIDE_STATUS_BUS_OE_O |-> EMPTY_SIDE_STATUS_BUS_O[0] == $past(e_src))
    else $error("empty bus bit zero wrong");
  AST_F_VAL: assert property (ALMOST_FULL_STATUS_BUS_OE_O |-> ALMOST_FULL_STATUS_BUS_O[0] == $past(f_src))
    else $error("full bus bit zero wrong");

  cover property (EMPTY_BUS_LEADER_PULSE_O);
  cover property ($fell(EMPTY_SIDE_STATUS_BUS_OE_O) && adr);
  cover property (ALMOST_FULL_STATUS_BUS_OE_O && adr);
endmodule : queue_flag_bus_expansion_asserts

bind queue_flag_bus_expansion queue_flag_bus_expansion_asserts #(.QUEUES(QUEUES)) u_asserts (
  .CLK_I(CLK_I), .RST_N_I(RST_N_I), .MASTER_RESET_N_I(MASTER_RESET_N_I),
  .FLAG_BUS_SELECT_STYLE_I(FLAG_BUS_SELECT_STYLE_I), .PACKET_MODE_SELECT_I(PACKET_MODE_SELECT_I),
  .DEVICE_NUMBER_PINS_I(DEVICE_NUMBER_PINS_I), .ALMOST_EMPTY_FLAG_I(ALMOST_EMPTY_FLAG_I),
  .PACKET_READY_FLAG_I(PACKET_READY_FLAG_I), .ALMOST_FULL_FLAG_I(ALMOST_FULL_FLAG_I),
  .READ_QUEUE_ADDRESS_I(READ_QUEUE_ADDRESS_I), .WRITE_QUEUE_ADDRESS_I(WRITE_QUEUE_ADDRESS_I),
  .EMPTY_BUS_STROBE_I(EMPTY_BUS_STROBE_I), .EMPTY_TOKEN_IN_I(EMPTY_TOKEN_IN_I),
  .FULL_BUS_STROBE_I(FULL_BUS_STROBE_I), .FULL_TOKEN_IN_I(FULL_TOKEN_IN_I),
  .EMPTY_TOKEN_OUT_O(EMPTY_TOKEN_OUT_O), .EMPTY_BUS_LEADER_PULSE_O(EMPTY_BUS_LEADER_PULSE_O),
  .EMPTY_SIDE_STATUS_BUS_OE_O(EMPTY_SIDE_STATUS_BUS_OE_O), .FULL_TOKEN_OUT_O(FULL_TOKEN_OUT_O),
  .FULL_BUS_LEADER_PULSE_O(FULL_BUS_LEADER_PULSE_O), .ALMOST_FULL_STATUS_BUS_OE_O(ALMOST_FULL_STATUS_BUS_OE_O),
  .EMPTY_SIDE_STATUS_BUS_O(EMPTY_SIDE_STATUS_BUS_O), .ALMOST_FULL_STATUS_BUS_O(ALMOST_FULL_STATUS_BUS_O)
);

// File: sim/queue_flag_bus_expansion_bench.sv
`timescale 1ns/1ps

module queue_flag_bus_expansion_bench;
  import flag_bus_pkg::*;
  logic clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, mrs_n = 0, style = 0, pkt = 0, lead = 0;
  logic empty_bus_strobe = 0, full_bus_strobe = 0, pready, pslverr, etin, etout, epul, eoe, ftin, ftout, fpul, foe, err;
  logic [7:0] paddr = 8'h00, ae = 8'hFE, pr = 8'hEB, af = 8'hF6, ebus, fbus;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [5:0] raddr = 6'h00, waddr = 6'h00;
  logic [2:0] devn = 3'h5;
  int n_fail = 0, n_tests = 0;
  // Five queues stay configured, so the three top bus bits read as inactive.
  localparam logic [7:0] UNUSED = 8'hE0;

  always #12.5 clk = ~clk;

  queue_flag_bus_expansion u_queue_flag_bus_expansion (.CLK_I(clk), .RST_N_I(rst_n), .PSEL_I(psel),
    .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
    .PSLVERR_O(pslverr), .MASTER_RESET_N_I(mrs_n), .FLAG_BUS_SELECT_STYLE_I(style), .PACKET_MODE_SELECT_I(pkt),
    .CHAIN_LEADER_SELECT_I(lead), .DEVICE_NUMBER_PINS_I(devn), .ALMOST_EMPTY_FLAG_I(ae), .PACKET_READY_FLAG_I(pr),
    .ALMOST_FULL_FLAG_I(af), .READ_QUEUE_ADDRESS_I(raddr), .EMPTY_BUS_STROBE_I(empty_bus_strobe), .EMPTY_TOKEN_IN_I(etin),
    .EMPTY_TOKEN_OUT_O(etout), .EMPTY_BUS_LEADER_PULSE_O(epul), .EMPTY_SIDE_STATUS_BUS_O(ebus),
    .EMPTY_SIDE_STATUS_BUS_OE_O(eoe), .WRITE_QUEUE_ADDRESS_I(waddr), .FULL_BUS_STROBE_I(full_bus_strobe),
    .FULL_TOKEN_IN_I(ftin), .FULL_TOKEN_OUT_O(ftout), .FULL_BUS_LEADER_PULSE_O(fpul),
    .ALMOST_FULL_STATUS_BUS_O(fbus), .ALMOST_FULL_STATUS_BUS_OE_O(foe));
  // Exactly one leader in the ring: the partner leads whenever this device does not.
  flag_ring_partner u_flag_ring_partner (.clk_i(clk), .rst_n_i(mrs_n), .leader_i(~lead), .token_in_i(etout),
    .token_out_o(etin));
  flag_ring_partner u_flag_ring_partner_f (.clk_i(clk), .rst_n_i(mrs_n), .leader_i(~lead), .token_in_i(ftout),
    .token_out_o(ftin));

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // Only the watchdog ends a wait for the answer; one idle edge follows each transfer.
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1; pwr <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; pen <= 1'b0;
    @(posedge clk);
  endtask : apb

  task mreset(input logic s, input logic p, input logic l);
    mrs_n <= 1'b0;
    repeat (2) @(posedge clk);
    style <= s; pkt <= p; lead <= l;
    repeat (2) @(posedge clk);
    mrs_n <= 1'b1;
  endtask : mreset

  task t_regs;
    apb(0, ADDR_CTRL, 0);  chk("ctrl reset", 8, rd);
    apb(1, ADDR_CTRL, 5);  chk("ctrl wr err", 0, err);
    apb(0, ADDR_CTRL, 0);  chk("ctrl read", 5, rd);
    apb(1, ADDR_STATUS, 1); chk("status wr err", 1, err);
    apb(0, 8'h08, 0);      chk("unmapped err", 1, err);
    $display("test regs done");
  endtask : t_regs

  // Outputs are read just after an edge, so each read shows what stood in the cycle before it.
  task t_addr;
    mreset(0, 0, 0);
    @(posedge clk);
    raddr <= {devn, 3'h3}; empty_bus_strobe <= 1'b1; waddr <= {devn, 3'h6}; full_bus_strobe <= 1'b1;
    @(posedge clk);
    empty_bus_strobe <= 1'b0; full_bus_strobe <= 1'b0;
    @(posedge clk);
    chk("e oe early", 0, eoe);
    @(posedge clk);
    chk("e oe", 1, eoe);
    chk("e bus", ae | UNUSED, ebus);
    chk("f oe", 1, foe);
    chk("f bus", af | UNUSED, fbus);
    chk("e token", 0, etout);
    raddr <= 6'h08; empty_bus_strobe <= 1'b1; waddr <= 6'h30; full_bus_strobe <= 1'b1; ae <= 8'hF9;
    @(posedge clk);
    empty_bus_strobe <= 1'b0; full_bus_strobe <= 1'b0;
    chk("e bus lag", 8'hFE | UNUSED, ebus);
    @(posedge clk);
    chk("e oe hold", 1, eoe);
    chk("e bus new", 8'hF9 | UNUSED, ebus);
    @(posedge clk);
    chk("e oe off", 0, eoe);
    chk("f oe off", 0, foe);
    $display("test addressed done");
  endtask : t_addr

  task t_poll;
    mreset(1, 1, 1);
    @(posedge clk);
    @(posedge clk);
    chk("e oe first", 1, eoe);
    chk("e pulse", 1, epul);
    chk("e token", 1, etout);
    chk("e bus pkt", pr | UNUSED, ebus);
    chk("f oe first", 1, foe);
    chk("f pulse", 1, fpul);
    chk("f token", 1, ftout);
    @(posedge clk);
    chk("e oe partner", 0, eoe);
    chk("e pulse off", 0, epul);
    chk("f token off", 0, ftout);
    @(posedge clk);
    chk("e oe again", 1, eoe);
    apb(0, ADDR_STATUS, 0);
    chk("status", 32'h27, rd & 32'h27);
    $display("test polled done");
  endtask : t_poll

  // Polled ring with the partner as leader: this device holds only after the token arrives.
  task t_follow;
    mreset(1, 0, 0);
    @(posedge clk);
    @(posedge clk);
    chk("e oe follower first", 0, eoe);
    chk("e token follower first", 0, etout);
    chk("f oe follower first", 0, foe);
    @(posedge clk);
    chk("e oe follower", 1, eoe);
    chk("e token follower", 1, etout);
    chk("e pulse follower", 0, epul);
    chk("e bus ae", 8'hF9 | UNUSED, ebus);
    chk("f token follower", 1, ftout);
    chk("f pulse follower", 0, fpul);
    @(posedge clk);
    chk("e oe follower off", 0, eoe);
    $display("test follower done");
  endtask : t_follow

  task complete_run;
    $display("compares %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : complete_run

  initial begin
    #200000;
    n_fail++;
    complete_run();
  end

  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    t_regs();
    t_addr();
    t_poll();
    t_follow();
    complete_run();
  end
endmodule : queue_flag_bus_expansion_bench
